// [core/trwsrc_pkg.sv]
package trwsrc_pkg;

  // register indices; the byte address is the index shifted by IDX_SHIFT
  localparam int          ADDR_W               = 12;
  localparam int          IDX_W                = 8;
  localparam int          IDX_SHIFT            = 2;
  localparam logic [7:0]  IDX_CONTROL          = 8'h00;
  localparam logic [7:0]  IDX_EVENT_CONTROL    = 8'h04;
  localparam logic [7:0]  IDX_IRQ_ENABLE_CLEAR = 8'h08;
  localparam logic [7:0]  IDX_IRQ_ENABLE_SET   = 8'h09;
  localparam logic [7:0]  IDX_IRQ_FLAGS        = 8'h0a;
  localparam logic [7:0]  IDX_RANDOM_OUTPUT    = 8'h20;

  // field positions
  localparam int          BIT_ENABLE           = 1;
  localparam int          BIT_RUN_IN_STANDBY   = 6;
  localparam int          BIT_EVENT_OUT_EN     = 0;
  localparam int          BIT_WORD_READY       = 0;

  // reset values
  localparam logic        RESET_BIT            = 1'b0;
  localparam logic [31:0] RESET_WORD           = 32'h00000000;
  localparam logic [31:0] READ_ZERO            = 32'h00000000;

  // data path and cadence
  localparam int          WORD_W               = 32;
  localparam int          BYTES                = WORD_W / 8;
  localparam int          FIFO_DEPTH           = 16;
  localparam int          WORD_PERIOD          = 84;
  localparam int          CNT_W                = 7;
  localparam logic [6:0]  CNT_ZERO             = 7'h00;
  localparam logic [6:0]  CNT_ONE              = 7'h01;
  localparam logic [6:0]  PERIOD_LAST          = 7'(WORD_PERIOD - 1);

  typedef struct packed {
    logic run_in_standby;
    logic enable;
  } trwsrc_ctrl_t;

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_COUNT,
    GEN_WAIT
  } trwsrc_gen_state_t;

endpackage

// [core/trwsrc.sv]
`timescale 1ns/1ps
// Operation
// [RL1] while enabled a fresh 32-bit word lands in the output register every 84 clocks unasked.
// [RL2] the event control register takes writes only while the enable bit is zero.
// [RL3] writing one to control bit 1 starts generation and writing zero stops it.
// [RL4] the word-ready flag (flag bit 0) is set whenever a new word is placed in the output.
// [RL5] the flag clears on a write of one or on a read of the output word; a zero write does nothing.
// [RL6] the interrupt line is high while the flag and its enable are both set.
// [RL7] enable-set and enable-clear write ones to set or clear one shared enable, read by both.
// [RL8] with event control bit 0 set each finished word emits one event pulse, else none.
// [RL9] run-in-standby (bit 6) keeps generation going in standby; at zero it halts, config kept.
// [RL10] the output register at index 0x20 returns the latest word to reads.
// [RL11] accesses of 8, 16 and 32 bits, byte and halfword parts included, are served whole.
// [RL12] write protect blocks every writable register except the flag register.
// [RL13] a cpu debug halt does not touch generation or the flag.
// [RL14] output word, flag set and event pulse all happen in one clock.

module trwsrc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_COUNT  = CW'(1);

  // storage is not reset; count alone says what is valid
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign next_count = push & ~pop ? count + ONE_COUNT :
                      pop & ~push ? count - ONE_COUNT : count;

  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap by compare, so depth need not be a power of two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
    end else if (ce && push) begin
      wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= '0;
    end else if (ce && pop) begin
      rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
  end

  // ready is registered so the source sees it straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= '0;
      in_ready <= 1'b0;
    end else if (ce) begin
      count    <= next_count;
      in_ready <= (next_count != FULL_COUNT);
    end
  end
endmodule // trwsrc_fifo

module trwsrc (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [trwsrc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         write_protect,
  input  wire logic                         standby,
  input  wire logic                         entropy_valid,
  input  wire logic [31:0]                  entropy_data,
  output logic                              entropy_ready,
  output logic                              irq,
  output logic                              word_ready_event
);

  function automatic logic addr_is(input logic [trwsrc_pkg::ADDR_W-1:0] a,
                                   input logic [trwsrc_pkg::IDX_W-1:0]  idx);
    return a == (trwsrc_pkg::ADDR_W'(idx) << trwsrc_pkg::IDX_SHIFT);
  endfunction

  trwsrc_pkg::trwsrc_ctrl_t      control_reg;
  trwsrc_pkg::trwsrc_gen_state_t gen_state;
  logic                          word_ready_event_out_en;
  logic                          irq_en;
  logic                          word_ready;
  logic [31:0]                   random_output;
  logic [trwsrc_pkg::CNT_W-1:0]  cnt;

  logic        hit_ctrl;
  logic        hit_event_control;
  logic        hit_enclr;
  logic        hit_enset;
  logic        hit_flags;
  logic        hit_data;
  logic        hit_any;
  logic        setup;
  logic        access;
  logic        wr_acc;
  logic        wr_ok;
  logic        refuse;
  logic        lane0;
  logic        running;
  logic        at_last;
  logic        gen_take;
  logic        gen_load;
  logic        flag_clear;
  logic        next_word_ready;
  logic        next_irq_en;
  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic [31:0] rd_word;
  // decoded write and read strobes
  logic        lane_ok;
  logic        ready_bit;
  logic        wr_ctrl;
  logic        wr_event_control;
  logic        set_irq_en;
  logic        clr_irq_en;
  logic        w1c_flag;
  logic        rd_data;
  logic        next_event;
  trwsrc_pkg::trwsrc_gen_state_t next_gen_state;
  logic [trwsrc_pkg::CNT_W-1:0]  next_cnt;

  // decode
  assign hit_ctrl   = addr_is(paddr, trwsrc_pkg::IDX_CONTROL);
  assign hit_event_control = addr_is(paddr, trwsrc_pkg::IDX_EVENT_CONTROL);
  assign hit_enclr  = addr_is(paddr, trwsrc_pkg::IDX_IRQ_ENABLE_CLEAR);
  assign hit_enset  = addr_is(paddr, trwsrc_pkg::IDX_IRQ_ENABLE_SET);
  assign hit_flags  = addr_is(paddr, trwsrc_pkg::IDX_IRQ_FLAGS);
  assign hit_data   = addr_is(paddr, trwsrc_pkg::IDX_RANDOM_OUTPUT);
  // unmapped addresses answer with an error and change nothing
  assign hit_any    = hit_ctrl | hit_event_control | hit_enclr | hit_enset | hit_flags | hit_data;

  // no wait state: pready comes from a flop, so every access takes two phases
  assign setup   = psel & ~penable & ~pready;
  assign access  = psel & penable & pready;
  assign refuse  = ~hit_any | (pwrite & write_protect & ~hit_flags); // RL12
  assign wr_acc  = access & pwrite;
  assign wr_ok   = wr_acc & ~pslverr;
  assign lane0   = pstrb[0];

  // write strobes; 8-bit registers live in lane 0 only
  assign lane_ok    = wr_ok & lane0;
  assign ready_bit  = pwdata[trwsrc_pkg::BIT_WORD_READY];
  assign wr_ctrl    = lane_ok & hit_ctrl; // RL3
  assign wr_event_control  = lane_ok & hit_event_control & ~control_reg.enable; // RL2
  assign set_irq_en = lane_ok & hit_enset & ready_bit; // RL7
  assign clr_irq_en = lane_ok & hit_enclr & ready_bit; // RL7
  assign w1c_flag   = lane_ok & hit_flags & ready_bit; // RL5 RL12
  assign rd_data    = access & ~pwrite & hit_data; // RL5

  // standby only halts when run-in-standby is low; debug halt has no input here
  assign running = control_reg.enable & (~standby | control_reg.run_in_standby); // RL9 RL13
  assign at_last = (cnt == trwsrc_pkg::PERIOD_LAST);
  assign gen_take = running & ((gen_state == trwsrc_pkg::GEN_COUNT & at_last) |
                               (gen_state == trwsrc_pkg::GEN_WAIT)); // RL1
  // the word, its flag and its event all key off gen_load
  assign gen_load = gen_take & fifo_valid; // RL14

  assign flag_clear = w1c_flag | rd_data; // RL5
  // a new word beats a clear in the same clock
  assign next_word_ready = gen_load | (word_ready & ~flag_clear); // RL4
  // set and clear sit at different addresses, so they never collide
  assign next_irq_en = set_irq_en | (irq_en & ~clr_irq_en); // RL7
  assign next_event  = gen_load & word_ready_event_out_en; // RL8

  always_comb begin
    rd_word = trwsrc_pkg::READ_ZERO;
    if (hit_ctrl) begin
      rd_word[trwsrc_pkg::BIT_ENABLE]         = control_reg.enable;
      rd_word[trwsrc_pkg::BIT_RUN_IN_STANDBY] = control_reg.run_in_standby;
    end else if (hit_event_control) begin
      rd_word[trwsrc_pkg::BIT_EVENT_OUT_EN] = word_ready_event_out_en;
    end else if (hit_enclr || hit_enset) begin
      rd_word[trwsrc_pkg::BIT_WORD_READY] = irq_en; // RL7
    end else if (hit_flags) begin
      rd_word[trwsrc_pkg::BIT_WORD_READY] = word_ready;
    end else if (hit_data) begin
      rd_word = random_output; // RL10
    end
  end

  // fifo decouples the entropy source from the fixed cadence
  trwsrc_fifo #(
    .WIDTH (trwsrc_pkg::WORD_W),
    .DEPTH (trwsrc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (entropy_valid),
    .in_data   (entropy_data),
    .in_ready  (entropy_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (gen_take)
  );

  // bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & refuse; // RL12
    end
  end

  // read data is caught at setup so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= trwsrc_pkg::READ_ZERO;
    end else if (ce && setup) begin
      prdata <= pwrite ? trwsrc_pkg::READ_ZERO : rd_word; // RL11
    end
  end

  // configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= '{run_in_standby: trwsrc_pkg::RESET_BIT,
                       enable:         trwsrc_pkg::RESET_BIT};
    end else if (ce && wr_ctrl) begin
      control_reg.enable         <= pwdata[trwsrc_pkg::BIT_ENABLE]; // RL3
      control_reg.run_in_standby <= pwdata[trwsrc_pkg::BIT_RUN_IN_STANDBY]; // RL9
    end
  end

  // writes while enabled are dropped without an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ready_event_out_en <= trwsrc_pkg::RESET_BIT;
    end else if (ce && wr_event_control) begin // RL2
      word_ready_event_out_en <= pwdata[trwsrc_pkg::BIT_EVENT_OUT_EN]; // RL8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= trwsrc_pkg::RESET_BIT;
    end else if (ce) begin
      irq_en <= next_irq_en; // RL7
    end
  end

  // generator cadence
  always_comb begin
    next_gen_state = gen_state;
    next_cnt       = cnt;
    case (gen_state)
      trwsrc_pkg::GEN_IDLE: begin
        next_cnt = trwsrc_pkg::CNT_ZERO;
        if (running) begin
          next_gen_state = trwsrc_pkg::GEN_COUNT;
        end
      end
      trwsrc_pkg::GEN_COUNT: begin
        if (!control_reg.enable) begin // RL3
          next_gen_state = trwsrc_pkg::GEN_IDLE;
        end else if (running && at_last) begin // RL1
          next_cnt = trwsrc_pkg::CNT_ZERO;
          if (!fifo_valid) begin
            next_gen_state = trwsrc_pkg::GEN_WAIT;
          end
        end else if (running) begin
          next_cnt = cnt + trwsrc_pkg::CNT_ONE;
        end
      end
      trwsrc_pkg::GEN_WAIT: begin
        // entropy starved: the word is late rather than stale
        if (!control_reg.enable) begin
          next_gen_state = trwsrc_pkg::GEN_IDLE;
        end else if (gen_load) begin
          next_gen_state = trwsrc_pkg::GEN_COUNT;
        end
      end
      default: begin
        next_gen_state = trwsrc_pkg::GEN_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_state <= trwsrc_pkg::GEN_IDLE;
      cnt       <= trwsrc_pkg::CNT_ZERO;
    end else if (ce) begin
      gen_state <= next_gen_state;
      cnt       <= next_cnt;
    end
  end

  // output word, software byte writes lose to a new word
  genvar b;
  generate
    for (b = 0; b < trwsrc_pkg::BYTES; b++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          random_output[8*b +: 8] <= trwsrc_pkg::RESET_WORD[8*b +: 8];
        end else if (ce) begin
          if (gen_load) begin
            random_output[8*b +: 8] <= fifo_data[8*b +: 8]; // RL1 RL14
          end else if (wr_ok && hit_data && pstrb[b]) begin
            random_output[8*b +: 8] <= pwdata[8*b +: 8]; // RL11
          end
        end
      end
    end
  endgenerate

  // flag, interrupt and event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ready <= trwsrc_pkg::RESET_BIT;
    end else if (ce) begin
      word_ready <= next_word_ready; // RL4 RL14
    end
  end

  // irq follows the next state so it never lags the flag by a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= next_word_ready & next_irq_en; // RL6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ready_event <= 1'b0;
    end else if (ce) begin
      word_ready_event <= next_event; // RL8 RL14
    end
  end

endmodule // trwsrc

// [bench/trwsrc_assertions.sv]
`timescale 1ns/1ps
module trwsrc_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        write_protect,
  input wire logic        irq,
  input wire logic        word_ready_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire  set_up = psel & !penable;
  wire  acc    = psel & penable & pready;
  logic [6:0] gap;
  // saturates so the first word after reset is never flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 7'h7f;
    else if (word_ready_event) gap <= 7'h00;
    else if (gap != 7'h7f) gap <= gap + 7'h01;
  end
  a_bus_answer: assert property (set_up |=> pready) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
  a_protect_err: assert property (set_up && pwrite && write_protect
    && paddr != 12'h028 |=> pslverr) else $error("protected write accepted");
  a_flag_open: assert property (set_up && pwrite && paddr == 12'h028 |=> !pslverr)
    else $error("flag write refused");
  a_word_cadence: assert property (word_ready_event |-> gap >= 7'h53)
    else $error("words too close");
  a_event_pulse: assert property (word_ready_event |=> !word_ready_event)
    else $error("event longer than a cycle");
  a_read_clears: assert property (acc && !pwrite && paddr == 12'h080
    |=> !irq || word_ready_event) else $error("data read left irq");
  a_irq_holds: assert property (irq && !(acc && (paddr == 12'h080
    || paddr == 12'h028 || paddr == 12'h020)) |=> irq) else $error("irq dropped alone");
  a_stop_quiet: assert property (acc && pwrite && paddr == 12'h000 && pstrb[0]
    && !pwdata[1] && !write_protect |=> ##1 !word_ready_event [*8])
    else $error("word after stop");
  cover property (word_ready_event);
  cover property (irq);
  cover property (pslverr);
endmodule // trwsrc_checker
bind trwsrc trwsrc_checker u_trwsrc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .write_protect(write_protect), .irq(irq),
  .word_ready_event(word_ready_event));

// [bench/trwsrc_test.sv]
`timescale 1ns/1ps
module trwsrc_test;
  logic        pclk, presetn, psel, penable, pwrite, write_protect, standby, e, ce;
  logic        entropy_valid, pready, pslverr, entropy_ready, irq, word_ready_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, entropy_data, xw, r, d, n;
  logic [3:0]  pstrb, s;
  logic [31:0] q[$];
  logic [11:0] regs[6] = '{12'h000, 12'h010, 12'h020, 12'h024, 12'h028, 12'h080};
  int          bad_count, num_checks, cyc, c;
  trwsrc u_trwsrc (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_protect(write_protect),
    .standby(standby), .entropy_valid(entropy_valid), .entropy_data(entropy_data),
    .entropy_ready(entropy_ready), .irq(irq), .word_ready_event(word_ready_event));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  // expected word after a strobed write of w over o
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) if (st[i]) o[8*i +: 8] = w[8*i +: 8];
    return o;
  endfunction
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic xe);
    apb(1'b1, a, dd, 4'hf);
    chk($sformatf("pslverr %h", a), 32'(xe), 32'(e));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'hf);
    chk($sformatf("reg %h", a), x, r);
  endtask
  task automatic wev();
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (word_ready_event !== 1'b1 && c < 300);
  endtask
  // entropy stream and scoreboard of accepted words, popped on each word_ready_event pulse
  always @(posedge pclk) begin
    if (entropy_valid && entropy_ready) q.push_back(entropy_data);
    if (word_ready_event === 1'b1) xw = q.pop_front();
    entropy_valid <= 1'($urandom);
    entropy_data <= $urandom;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {psel, penable, pwrite, write_protect, standby, presetn} = 6'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    void'($urandom(40994));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rd(regs[i], 32'h0);
    apb(1'b0, 12'h004, 32'h0, 4'hf);
    chk("unmapped err", 32'h1, 32'(e));
    wr(12'h010, 32'h1, 1'b0);
    wr(12'h024, 32'h1, 1'b0);
    rd(12'h020, 32'h1);
    wr(12'h000, 32'h2, 1'b0);
    wev();
    chk("first word", 32'h1, 32'(c < 300));
    chk("irq", 32'h1, 32'(irq));
    rd(12'h028, 32'h1);
    apb(1'b0, 12'h080, 32'h0, 4'hf);
    chk("word", xw, r);
    rd(12'h028, 32'h0);
    chk("irq clear", 32'h0, 32'(irq));
    wev();
    wev();
    chk("period", 32'd84, 32'(c));
    wr(12'h028, 32'h0, 1'b0);
    rd(12'h028, 32'h1);
    write_protect <= 1'b1;
    wr(12'h028, 32'h1, 1'b0);
    rd(12'h028, 32'h0);
    wr(12'h000, 32'h0, 1'b1);
    rd(12'h000, 32'h2);
    write_protect <= 1'b0;
    wr(12'h010, 32'h0, 1'b0);
    rd(12'h010, 32'h1);
    wr(12'h000, 32'h0, 1'b0);
    wev();
    chk("stopped", 32'd300, 32'(c));
    d = $urandom;
    n = $urandom;
    s = 4'($urandom);
    wr(12'h080, d, 1'b0);
    apb(1'b1, 12'h080, n, s);
    rd(12'h080, merge(d, n, s));
    apb(1'b1, 12'h080, 32'h0, 4'b0010);
    rd(12'h080, merge(merge(d, n, s), 32'h0, 4'b0010));
    standby <= 1'b1;
    wr(12'h000, 32'h2, 1'b0);
    wev();
    chk("standby halt", 32'd300, 32'(c));
    wr(12'h000, 32'h42, 1'b0);
    wev();
    chk("standby run", 32'h1, 32'(c < 300));
    wr(12'h020, 32'h1, 1'b0);
    rd(12'h024, 32'h0);
    chk("irq off", 32'h0, 32'(irq));
    ce <= 1'b0;
    wev();
    chk("ce freeze", 32'd300, 32'(c));
    ce <= 1'b1;
    wr(12'h000, 32'h0, 1'b0);
    wr(12'h010, 32'h0, 1'b0);
    rd(12'h010, 32'h0);
    wr(12'h028, 32'h1, 1'b0);
    wr(12'h000, 32'h42, 1'b0);
    wev();
    chk("event off", 32'd300, 32'(c));
    rd(12'h028, 32'h1);
    complete_run();
  end
endmodule // trwsrc_test
